// *** src/ppim_params.svh ***
// register offsets, reset values and field layout for the pin port
`ifndef PPIM_PARAMS_SVH
`define PPIM_PARAMS_SVH

`define PPIM_NPINS          26
`define PPIM_OFF_DATA       8'h00
`define PPIM_OFF_DIR        8'h04
`define PPIM_OFF_PULL       8'h08
`define PPIM_OFF_DRIVE      8'h0C
`define PPIM_OFF_SENSE      8'h10
`define PPIM_OFF_BOTH       8'h14
`define PPIM_OFF_POL        8'h18
`define PPIM_OFF_MASK       8'h1C
`define PPIM_OFF_MSTAT      8'h24
`define PPIM_OFF_CLEAR      8'h28
`define PPIM_OFF_FUNC0      8'h2C
`define PPIM_OFF_FUNC1      8'h30
`define PPIM_OFF_FUNC2      8'h34
`define PPIM_OFF_FUNC3      8'h38
`define PPIM_OFF_SET        8'h3C
`define PPIM_OFF_CLR        8'h40
`define PPIM_OFF_TSEL       8'h44
`define PPIM_PULL_RST       26'h3FFFFFF
`define PPIM_FUNC_GPIO      3'h0
`define PPIM_FUNC_ALT1      3'h1
`define PPIM_FUNC_ALT0      3'h4
`define PPIM_FUNC_ALT2      3'h5
`define PPIM_PIN9           9
`define PPIM_PIN10          10
`define PPIM_FUNC_W         3
`define PPIM_NIB            4
`define PPIM_SEL_W          8
`define PPIM_SEL_MAX        8'h19

`endif

// *** src/ppim_pkg.sv ***
// types shared by the pin port design
`default_nettype none
package ppim_pkg;
  typedef struct packed {
    logic [25:0] out_val;
    logic [25:0] out_en;
    logic [25:0] pull_en;
    logic [25:0] drive_hi;
  } ppim_pad_t;

  typedef struct packed {
    logic [25:0] alt0;
    logic [25:0] alt1;
    logic [25:0] alt2;
  } ppim_alt_t;

  typedef struct packed {
    logic t1_a;
    logic t1_b;
    logic t2_a;
    logic t2_b;
  } ppim_cap_t;
endpackage

`default_nettype wire

// *** src/ppim_port.sv ***
// pin port: apb registers, pin mux, pin events and timer capture routing
// ---------------------------------------------------------------
// Operation
// - gpio output pins drive stored data
// - data read returns sampled pin levels
// - direction register, one means output
// - pull enables, reset all 26 set
// - drive strength bit per pin
// - sense select: edge or level
// - both-edges option for edge mode
// - polarity selects falling/low or rising/high
// - mask passes pin event to irq
// - masked status read-only, writes ignored
// - clear register: one clears pending event
// - 3-bit function fields, nibble spaced, reserved zero
// - pins 9 and 10 reset to function one
// - set register sets gpio data bits
// - clear register clears gpio data bits
// - four 8-bit timer capture pin selectors
// - function codes: gpio, alt one, zero, two
// - selected pin feeds timer capture input
// - pins high impedance during reset
// ---------------------------------------------------------------
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "ppim_params.svh"

module ppim_port (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst_n,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // pads
  input  wire logic [25:0]       pin_in,
  output ppim_pkg::ppim_pad_t    pad,
  // alternate functions
  input  wire ppim_pkg::ppim_alt_t alt_out,
  input  wire ppim_pkg::ppim_alt_t alt_oe,
  output ppim_pkg::ppim_alt_t    alt_in,
  // timers and interrupt
  output ppim_pkg::ppim_cap_t    capture,
  output logic                   irq
);
  import ppim_pkg::*;

  localparam int N = `PPIM_NPINS;

  logic [N-1:0]  data_ff, dir_ff, pull_ff, drive_ff;
  logic [N-1:0]  sense_ff, both_ff, pol_ff, mask_ff;
  logic [N-1:0]  pend_ff, pin_prev_ff, pin_now_ff;
  logic [2:0]    func_ff [N];
  logic [31:0]   tsel_ff;
  logic [31:0]   nxt_prdata;
  logic [N-1:0]  is_gpio, drv_val, drv_en, edge_hit, level_hit, raw_evt, mstat;
  logic [N-1:0]  alt0_sel, alt1_sel, alt2_sel;
  logic          wr_en, rd_en;
  logic [N-1:0]  wmask;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign wmask = pwdata[N-1:0];

  // ---------------------------------------------------------------
  // per-pin mux and event detect
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_pin
      assign is_gpio[g]  = (func_ff[g] == `PPIM_FUNC_GPIO);
      assign alt1_sel[g] = (func_ff[g] == `PPIM_FUNC_ALT1);
      assign alt0_sel[g] = (func_ff[g] == `PPIM_FUNC_ALT0);
      assign alt2_sel[g] = (func_ff[g] == `PPIM_FUNC_ALT2);
      always_comb
      begin
        drv_val[g] = data_ff[g];
        drv_en[g]  = is_gpio[g] & dir_ff[g];
        if (alt0_sel[g])
        begin
          drv_val[g] = alt_out.alt0[g];
          drv_en[g]  = alt_oe.alt0[g];
        end
        else if (alt1_sel[g])
        begin
          drv_val[g] = alt_out.alt1[g];
          drv_en[g]  = alt_oe.alt1[g];
        end
        else if (alt2_sel[g])
        begin
          drv_val[g] = alt_out.alt2[g];
          drv_en[g]  = alt_oe.alt2[g];
        end
      end
      // edge seen between two samples of the pin
      assign edge_hit[g] = (pin_now_ff[g] != pin_prev_ff[g]) &&
                           (both_ff[g] || (pin_now_ff[g] == pol_ff[g]));
      assign level_hit[g] = (pin_now_ff[g] == pol_ff[g]);
      assign raw_evt[g] = sense_ff[g] ? level_hit[g] : edge_hit[g];
    end
  endgenerate

  assign mstat = pend_ff & mask_ff;

  // ---------------------------------------------------------------
  // pin sampling
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_now_ff  <= '0;
      pin_prev_ff <= '0;
    end
    else
    begin
      pin_now_ff  <= pin_in;
      pin_prev_ff <= pin_now_ff;
    end
  end

  // ---------------------------------------------------------------
  // output data with atomic set and clear
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      data_ff <= '0;
    else if (wr_en && paddr == `PPIM_OFF_DATA)
      data_ff <= wmask;
    else if (wr_en && paddr == `PPIM_OFF_SET)
      data_ff <= data_ff | (wmask & is_gpio);
    else if (wr_en && paddr == `PPIM_OFF_CLR)
      data_ff <= data_ff & ~(wmask & is_gpio);
  end

  // ---------------------------------------------------------------
  // pad configuration
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dir_ff   <= '0;
      pull_ff  <= `PPIM_PULL_RST;
      drive_ff <= '0;
    end
    else if (wr_en)
    begin
      if (paddr == `PPIM_OFF_DIR)
        dir_ff <= wmask;
      if (paddr == `PPIM_OFF_PULL)
        pull_ff <= wmask;
      if (paddr == `PPIM_OFF_DRIVE)
        drive_ff <= wmask;
    end
  end

  // ---------------------------------------------------------------
  // event configuration
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sense_ff <= '0;
      both_ff  <= '0;
      pol_ff   <= '0;
      mask_ff  <= '0;
    end
    else if (wr_en)
    begin
      if (paddr == `PPIM_OFF_SENSE)
        sense_ff <= wmask;
      if (paddr == `PPIM_OFF_BOTH)
        both_ff <= wmask;
      if (paddr == `PPIM_OFF_POL)
        pol_ff <= wmask;
      if (paddr == `PPIM_OFF_MASK)
        mask_ff <= wmask;
    end
  end

  // ---------------------------------------------------------------
  // pending events; a new event beats a clear in the same cycle
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      pend_ff <= '0;
    else if (wr_en && paddr == `PPIM_OFF_CLEAR)
      pend_ff <= (pend_ff & ~wmask) | raw_evt;
    else
      pend_ff <= pend_ff | raw_evt;
  end

  // ---------------------------------------------------------------
  // function select and timer routing
  // ---------------------------------------------------------------
  generate
    for (g = 0; g < N; g++)
    begin : g_func
      always_ff @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
          func_ff[g] <= (g == `PPIM_PIN9 || g == `PPIM_PIN10) ?
                        `PPIM_FUNC_ALT1 : `PPIM_FUNC_GPIO;
        else if (wr_en && paddr == 8'(`PPIM_OFF_FUNC0 + (g / 8) * 4))
          func_ff[g] <= pwdata[(g % 8) * `PPIM_NIB +: `PPIM_FUNC_W];
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      tsel_ff <= '0;
    else if (wr_en && paddr == `PPIM_OFF_TSEL)
      tsel_ff <= pwdata;
  end

  function automatic logic pick(input logic [7:0] sel, input logic [N-1:0] p);
    pick = (sel <= `PPIM_SEL_MAX) ? p[5'(sel)] : 1'b0;
  endfunction

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_prdata = '0;
    case (paddr)
      `PPIM_OFF_DATA:  nxt_prdata[N-1:0] = pin_now_ff;
      `PPIM_OFF_DIR:   nxt_prdata[N-1:0] = dir_ff;
      `PPIM_OFF_PULL:  nxt_prdata[N-1:0] = pull_ff;
      `PPIM_OFF_DRIVE: nxt_prdata[N-1:0] = drive_ff;
      `PPIM_OFF_SENSE: nxt_prdata[N-1:0] = sense_ff;
      `PPIM_OFF_BOTH:  nxt_prdata[N-1:0] = both_ff;
      `PPIM_OFF_POL:   nxt_prdata[N-1:0] = pol_ff;
      `PPIM_OFF_MASK:  nxt_prdata[N-1:0] = mask_ff;
      `PPIM_OFF_MSTAT: nxt_prdata[N-1:0] = mstat;
      `PPIM_OFF_TSEL:  nxt_prdata = tsel_ff;
      default:
      begin
        for (int i = 0; i < N; i++)
          if (paddr == 8'(`PPIM_OFF_FUNC0 + (i / 8) * 4))
            nxt_prdata[(i % 8) * `PPIM_NIB +: `PPIM_FUNC_W] = func_ff[i];
      end
    endcase
  end

  // ---------------------------------------------------------------
  // apb answer: no wait state, data registered in setup
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (rd_en)
        prdata <= nxt_prdata;
    end
  end

  // ---------------------------------------------------------------
  // registered pin, alternate, capture and irq outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pad     <= '{default: '0};
      alt_in  <= '{default: '0};
      capture <= '0;
      irq     <= 1'b0;
    end
    else
    begin
      pad.out_val  <= drv_val;
      pad.out_en   <= drv_en;
      pad.pull_en  <= pull_ff;
      pad.drive_hi <= drive_ff;
      alt_in.alt0  <= pin_now_ff & alt0_sel;
      alt_in.alt1  <= pin_now_ff & alt1_sel;
      alt_in.alt2  <= pin_now_ff & alt2_sel;
      capture.t1_a <= pick(tsel_ff[7:0], pin_now_ff);
      capture.t1_b <= pick(tsel_ff[15:8], pin_now_ff);
      capture.t2_a <= pick(tsel_ff[23:16], pin_now_ff);
      capture.t2_b <= pick(tsel_ff[31:24], pin_now_ff);
      irq          <= |mstat;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_irq_follows: assert property (@(posedge clock) disable iff (!rst_n)
    ##1 irq == |$past(mstat))
    else $error("irq does not follow masked status");

  chk_clear_bit: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_en && paddr == `PPIM_OFF_CLEAR && pwdata[0] && !raw_evt[0]) |=> !pend_ff[0])
    else $error("clear did not drop pending bit");

  chk_set_data: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_en && paddr == `PPIM_OFF_SET && pwdata[3] && is_gpio[3]) |=> data_ff[3])
    else $error("set register missed gpio bit");

  chk_clr_data: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_en && paddr == `PPIM_OFF_CLR && pwdata[3] && is_gpio[3]) |=> !data_ff[3])
    else $error("clear register missed gpio bit");

  chk_level_hold: assert property (@(posedge clock) disable iff (!rst_n)
    (sense_ff[13] && level_hit[13]) |=> pend_ff[13])
    else $error("level event not pending");

  chk_drive_pin: assert property (@(posedge clock) disable iff (!rst_n)
    (is_gpio[2] && dir_ff[2]) |=> (pad.out_en[2] && pad.out_val[2] == $past(data_ff[2])))
    else $error("gpio output not driven");

  chk_input_hiz: assert property (@(posedge clock) disable iff (!rst_n)
    (is_gpio[4] && !dir_ff[4]) |=> !pad.out_en[4])
    else $error("input pin driven");

  chk_read_pin: assert property (@(posedge clock) disable iff (!rst_n)
    (rd_en && paddr == `PPIM_OFF_DATA) |=> prdata[N-1:0] == $past(pin_now_ff))
    else $error("data read not pin level");

  chk_capture_route: assert property (@(posedge clock) disable iff (!rst_n)
    (tsel_ff[7:0] == `PPIM_SEL_MAX) |=> capture.t1_a == $past(pin_now_ff[N-1]))
    else $error("capture routing wrong");

  chk_clear_keep: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_en && paddr == `PPIM_OFF_CLEAR && !pwdata[13] && pend_ff[13]) |=> pend_ff[13])
    else $error("clear with zero dropped pending bit");

  chk_both_edges: assert property (@(posedge clock) disable iff (!rst_n)
    (!sense_ff[13] && both_ff[13] && pin_now_ff[13] != pin_prev_ff[13]) |=> pend_ff[13])
    else $error("both-edge event missed");

  chk_single_edge: assert property (@(posedge clock) disable iff (!rst_n)
    (!sense_ff[13] && !both_ff[13] && !pend_ff[13] &&
     (pin_now_ff[13] != pol_ff[13] || pin_now_ff[13] == pin_prev_ff[13])) |=> !pend_ff[13])
    else $error("event raised on wrong edge");

  chk_status_ro: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_en && paddr == `PPIM_OFF_MSTAT) |=> $stable(mask_ff))
    else $error("status write changed mask");

  chk_capture_range: assert property (@(posedge clock) disable iff (!rst_n)
    (tsel_ff[31:24] > `PPIM_SEL_MAX) |=> !capture.t2_b)
    else $error("out of range selector routed a pin");

  chk_alt_route: assert property (@(posedge clock) disable iff (!rst_n)
    alt1_sel[12] |=> alt_in.alt1[12] == $past(pin_now_ff[12]))
    else $error("alternate input not routed");

endmodule // ppim_port

`default_nettype wire

// *** tb/ppim_pin_model.sv ***
// pad-side model: resolves pin levels from device, outside drivers and pulls
`timescale 1ns/100ps
`default_nettype none

module ppim_pin_model (
  // clock
  input  wire logic                clock,
  // device pads
  input  wire ppim_pkg::ppim_pad_t pad,
  // outside drivers
  input  wire logic [25:0]         ext_en,
  input  wire logic [25:0]         ext_val,
  // resolved levels
  output logic [25:0]              pin_lvl
);
  import ppim_pkg::*;
  logic tog_ff = 1'b0;

  // a floating pin keeps changing so that no settled unknown slips through
  always_ff @(posedge clock)
    tog_ff <= ~tog_ff;

  always_comb
    for (int i = 0; i < 26; i++)
      if (pad.out_en[i])
        pin_lvl[i] = pad.out_val[i];
      else if (ext_en[i])
        pin_lvl[i] = ext_val[i];
      else if (pad.pull_en[i])
        pin_lvl[i] = 1'b0;
      else
        pin_lvl[i] = tog_ff;
endmodule // ppim_pin_model
`default_nettype wire

// *** tb/ppim_port_tb.sv ***
// self-checking bench for the pin port
`timescale 1ns/100ps
`default_nettype none

module ppim_port_tb;
  import ppim_pkg::*;
  // ---------------------------------------------
  // signals
  // ---------------------------------------------
  logic        clock;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic [25:0] pin_in;
  logic [25:0] ext_en;
  logic [25:0] ext_val;
  ppim_pad_t   pad;
  ppim_alt_t   alt_out;
  ppim_alt_t   alt_oe;
  ppim_alt_t   alt_in;
  ppim_cap_t   capture;
  logic        irq;
  int          n_mismatch;
  int          num_checks;
  logic [31:0] rv;
  logic        re;
  localparam logic [7:0] RST_A [15] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C,
    8'h24, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h38, 8'h44, 8'h20};
  localparam logic [31:0] RST_V [15] = '{32'h0, 32'h03FFFFFF, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h0, 32'h0, 32'h0, 32'h0, 32'h00000110, 32'h0, 32'h0, 32'h0, 32'h0};

  ppim_port i_dut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .pin_in(pin_in), .pad(pad), .alt_out(alt_out), .alt_oe(alt_oe),
    .alt_in(alt_in), .capture(capture), .irq(irq));
  ppim_pin_model i_pins (.clock(clock), .pad(pad), .ext_en(ext_en), .ext_val(ext_val),
    .pin_lvl(pin_in));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // held until pready is seen high at an edge, then released
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do
    begin
      @(posedge clock);
    end
    while (pready !== 1'b1);
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    check(rv, e);
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task automatic t_reset;
    for (int i = 0; i < 15; i++)
      rdchk(RST_A[i], RST_V[i]);
    check({6'h00, pad.pull_en}, 32'h03FFFFFF);
    $display("test reset done");
  endtask

  task automatic t_regs;
    for (int i = 0; i < 7; i++)
    begin
      wr(RST_A[i], 32'h02A5A5A5);
      rdchk(RST_A[i], 32'h02A5A5A5);
    end
    check({6'h00, pad.pull_en}, 32'h02A5A5A5);
    check({6'h00, pad.drive_hi}, 32'h02A5A5A5);
    for (int i = 0; i < 7; i++)
      wr(RST_A[i], RST_V[i]);
    wr(8'h2C, 32'hFFFFFFFF);
    rdchk(8'h2C, 32'h77777777);
    wr(8'h38, 32'hFFFFFFFF);
    rdchk(8'h38, 32'h00000077);
    wr(8'h24, 32'hFFFFFFFF);
    check({31'h0, re}, 32'h0);
    rdchk(8'h24, 32'h0);
    wr(8'h2C, 32'h0);
    wr(8'h38, 32'h0);
    $display("test regs done");
  endtask

  task automatic t_gpio;
    ext_en <= 26'h0001000;
    ext_val <= 26'h0001000;
    wr(8'h04, 32'h000002FF);
    wr(8'h00, 32'h000001A5);
    // pin 9 still in alternate use, so its set is dropped
    wr(8'h3C, 32'h0000025A);
    wr(8'h40, 32'h0000000F);
    // pads are registered one edge after the data register
    wait_n(1);
    check({6'h00, pad.out_en}, 32'h000000FF);
    check({6'h00, pad.out_val & pad.out_en}, 32'h000000F0);
    wr(8'h30, 32'h0);
    wait_n(2);
    check({6'h00, pad.out_en}, 32'h000002FF);
    check({6'h00, pad.out_val & pad.out_en}, 32'h000000F0);
    rdchk(8'h00, 32'h000010F0);
    $display("test gpio done");
  endtask

  task automatic t_alt;
    logic [2:0] code [4] = '{3'h0, 3'h1, 3'h4, 3'h5};
    logic [3:0] exp [4] = '{4'b0000, 4'b1010, 4'b1100, 4'b1001};
    alt_out <= {3{26'h0001000}};
    alt_oe <= {3{26'h0001000}};
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h30, {13'h0, code[i], 16'h0});
      wait_n(3);
      check({28'h0, pad.out_en[12], alt_in.alt0[12], alt_in.alt1[12], alt_in.alt2[12]},
        {28'h0, exp[i]});
    end
    wr(8'h30, 32'h0);
    alt_out <= '0;
    alt_oe <= '0;
    $display("test alt done");
  endtask

  task automatic t_irq;
    ext_en <= 26'h0003000;
    ext_val <= 26'h0001000;
    wr(8'h18, 32'h00002000);
    wait_n(4);
    wr(8'h28, 32'h03FFFFFF);
    rdchk(8'h24, 32'h0);
    ext_val <= 26'h0003000;
    wait_n(4);
    rdchk(8'h24, 32'h0);
    check({31'h0, irq}, 32'h0);
    wr(8'h1C, 32'h00002000);
    rdchk(8'h24, 32'h00002000);
    check({31'h0, irq}, 32'h1);
    wr(8'h24, 32'h0);
    wr(8'h28, 32'h0);
    rdchk(8'h24, 32'h00002000);
    wr(8'h28, 32'h00002000);
    rdchk(8'h24, 32'h0);
    check({31'h0, irq}, 32'h0);
    ext_val <= 26'h0001000;
    wait_n(4);
    rdchk(8'h24, 32'h0);
    wr(8'h14, 32'h00002000);
    ext_val <= 26'h0003000;
    wait_n(4);
    wr(8'h28, 32'h00002000);
    ext_val <= 26'h0001000;
    wait_n(4);
    rdchk(8'h24, 32'h00002000);
    wr(8'h10, 32'h00002000);
    ext_val <= 26'h0003000;
    wait_n(4);
    wr(8'h28, 32'h00002000);
    wait_n(2);
    rdchk(8'h24, 32'h00002000);
    ext_val <= 26'h0001000;
    wait_n(4);
    wr(8'h28, 32'h00002000);
    rdchk(8'h24, 32'h0);
    wr(8'h10, 32'h0);
    wr(8'h14, 32'h0);
    wr(8'h1C, 32'h0);
    $display("test irq done");
  endtask

  task automatic t_cap;
    ext_en <= 26'h2003000;
    ext_val <= 26'h2002000;
    wr(8'h44, 32'h1A0D0C19);
    rdchk(8'h44, 32'h1A0D0C19);
    wait_n(3);
    check({28'h0, capture}, 32'h0000000A);
    $display("test capture done");
  endtask

  // ---------------------------------------------
  // sequence and watchdog
  // ---------------------------------------------
  initial
  begin
    #500000;
    n_mismatch++;
    finish_test();
  end

  initial
  begin
    n_mismatch = 0;
    num_checks = 0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    alt_out = '0;
    alt_oe = '0;
    ext_en = '0;
    ext_val = '0;
    repeat (4) @(posedge clock);
    check({6'h00, pad.out_en}, 32'h0);
    rst_n <= 1'b1;
    @(posedge clock);
    t_reset();
    t_regs();
    t_gpio();
    t_alt();
    t_irq();
    t_cap();
    finish_test();
  end
endmodule // ppim_port_tb
`default_nettype wire
